// >>> core/i2cmsa_baud_timer.sv
// baud timer: reloadable down counter; expiry flag stays high while running at zero until reload or stop
`timescale 1ns/1ps
module i2cmsa_baud_timer (
    // clock and reset
    input  wire logic                                   clk_sys,
    input  wire logic                                   nrst,
    // control
    input  wire logic                                   load,
    input  wire logic                                   run,
    input  wire logic [i2cmsa_pkg::RELOAD_WIDTH-1:0]    reloadValue,
    // status
    output logic                                        expired
);
    logic [i2cmsa_pkg::RELOAD_WIDTH-1:0] count;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            count   <= '0;
            expired <= 1'b0;
        end else if (load) begin
            count   <= reloadValue;
            expired <= 1'b0;
        end else if (run && count != '0) begin
            count   <= count - 1'b1;
            expired <= (count == 7'h01);
        end else if (run) begin
            expired <= 1'b1;
        end else begin
            expired <= 1'b0;
        end
    end
endmodule

// >>> core/i2cmsa_core.sv
// start generation, collision and arbitration monitoring with an ahb-lite register slave
//
// Contract
// - software sets start request; both lines are sampled before anything else
// - both lines high loads baud timer from 7-bit reload and starts it
// - lines still high at expiry: pull data low, set start-seen flag
// - second expiry clears start request, stops timer, data stays low
// - line low at start or clock low early: collision flag, abort, idle
// - transmit buffer write during start is dropped and sets write collision
// - low five request bits ignore writes until the start completes
// - in sleep, a completed byte or match wakes the processor if enabled
// - reset disables the port and ends any transfer
// - start-seen and stop-seen clear on reset and while disabled
// - busy bus with interrupt enabled: stop detection raises the interrupt
// - sampled data compared with driven level; loss sets collision flag
// - arbitration checked in address, data, start, repeated start, acknowledge
// - collision during transmit halts it and clears buffer-full; any collision releases lines
// - collision in a condition aborts it, releases lines, clears requests
// - after collision the next buffer write restarts from the first bit
`timescale 1ns/1ps
module i2cmsa_core (
    // clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           nrst,
    // ahb-lite slave
    input  wire logic                           hsel,
    input  wire logic [7:0]                     haddr,
    input  wire logic [1:0]                     htrans,
    input  wire logic                           hwrite,
    input  wire logic [2:0]                     hsize,
    input  wire logic [31:0]                    hwdata,
    input  wire logic                           hready,
    output logic [31:0]                         hrdata,
    output logic                                hreadyout,
    output logic                                hresp,
    // two-wire bus pins
    input  wire logic                           sdaIn,
    input  wire logic                           sclIn,
    output logic                                sdaOut,
    output logic                                sdaOe,
    output logic                                sclOut,
    output logic                                sclOe,
    // datapath hooks
    input  wire logic                           byteDone,
    input  wire logic                           addrMatch,
    input  wire logic                           txActive,
    input  wire logic                           intendSda,
    input  wire logic                           arbPhase,
    // system
    output logic                                portIrq,
    output logic                                wakeReq,
    output logic                                txRestart
);
    // pin synchronisers
    i2cmsa_pkg::i2cmsa_lines_t linesMeta;
    i2cmsa_pkg::i2cmsa_lines_t lines;
    i2cmsa_pkg::i2cmsa_lines_t linesPrev;
    i2cmsa_pkg::i2cmsa_drive_t drive;

    // registers
    logic                                       portEnable;
    logic                                       irqEnable;
    logic                                       sleepMode;
    logic [i2cmsa_pkg::CTRL2_REQ_WIDTH-1:0]     second_control_reg;
    logic [i2cmsa_pkg::RELOAD_WIDTH-1:0]        baud_reload_value;
    logic [7:0]                                 transmit_buffer;
    logic                                       buffer_full_flag;
    logic                                       start_seen;
    logic                                       stop_seen;
    logic                                       collision_flag;
    logic                                       write_collision_flag;
    logic                                       port_event_flag;
    logic                                       busBusy;
    logic                                       afterColl;
    // bus control
    logic                                       dpValid;
    logic                                       dpWrite;
    logic [7:0]                                 dpAddr;
    logic                                       wrEn;
    // start sequence
    i2cmsa_pkg::i2cmsa_state_t                  state;
    i2cmsa_pkg::i2cmsa_state_t                  next_state;
    logic                                       timerLoad;
    logic                                       timerRun;
    logic                                       timerExpired;
    logic                                       startDone;
    logic                                       startColl;
    logic                                       arbLost;
    logic                                       collEvent;
    logic                                       startEdge;
    logic                                       stopEdge;
    logic                                       startBusy;

    function automatic logic isWrite(input logic [7:0] a);
        isWrite = wrEn && dpAddr == a;
    endfunction

    // two-flop synchronisers on the pins
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            linesMeta <= '1;
            lines     <= '1;
            linesPrev <= '1;
        end else begin
            linesMeta <= '{sda: sdaIn, scl: sclIn};
            lines     <= linesMeta;
            linesPrev <= lines;
        end
    end

    // ahb-lite address phase capture, zero wait states
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            dpValid <= 1'b0;
            dpWrite <= 1'b0;
            dpAddr  <= i2cmsa_pkg::BYTE_RESET;
        end else if (hready) begin
            dpValid <= hsel && htrans == i2cmsa_pkg::HTRANS_NONSEQ
                       && hsize == i2cmsa_pkg::HSIZE_WORD;
            dpWrite <= hwrite;
            dpAddr  <= haddr;
        end
    end

    assign wrEn      = dpValid && dpWrite;
    assign startBusy = state != i2cmsa_pkg::ST_IDLE;

    always_ff @(posedge clk_sys) begin
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
    end

    // read data registered in the address phase
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            hrdata <= i2cmsa_pkg::WORD_ZERO;
        end else if (hready && hsel && !hwrite) begin
            hrdata <= i2cmsa_pkg::WORD_ZERO;
            case (haddr)
                i2cmsa_pkg::CTRL_ADDR: begin
                    hrdata[i2cmsa_pkg::CTRL_EN_BIT]    <= portEnable;
                    hrdata[i2cmsa_pkg::CTRL_IE_BIT]    <= irqEnable;
                    hrdata[i2cmsa_pkg::CTRL_SLEEP_BIT] <= sleepMode;
                end
                i2cmsa_pkg::CTRL2_ADDR: begin
                    hrdata[i2cmsa_pkg::CTRL2_REQ_WIDTH-1:0] <= second_control_reg;
                end
                i2cmsa_pkg::STATUS_ADDR: begin
                    hrdata[i2cmsa_pkg::ST_BUSY_BIT]       <= busBusy;
                    hrdata[i2cmsa_pkg::ST_BFULL_BIT]      <= buffer_full_flag;
                    hrdata[i2cmsa_pkg::ST_START_SEEN_BIT] <= start_seen;
                    hrdata[i2cmsa_pkg::ST_STOP_SEEN_BIT]  <= stop_seen;
                    hrdata[i2cmsa_pkg::ST_COLL_BIT]       <= collision_flag;
                    hrdata[i2cmsa_pkg::ST_WRITE_COLLISION_FLAG_BIT]       <= write_collision_flag;
                    hrdata[i2cmsa_pkg::ST_EVENT_BIT]      <= port_event_flag;
                end
                i2cmsa_pkg::RELOAD_ADDR: begin
                    hrdata[i2cmsa_pkg::RELOAD_WIDTH-1:0] <= baud_reload_value;
                end
                i2cmsa_pkg::TXBUF_ADDR: begin
                    hrdata[7:0] <= transmit_buffer;
                end
                default: hrdata <= i2cmsa_pkg::WORD_ZERO;
            endcase
        end
    end

    // control register and reload value
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            portEnable        <= 1'b0;
            irqEnable         <= 1'b0;
            sleepMode         <= 1'b0;
            baud_reload_value <= i2cmsa_pkg::RELOAD_RESET;
        end else begin
            if (isWrite(i2cmsa_pkg::CTRL_ADDR)) begin
                portEnable <= hwdata[i2cmsa_pkg::CTRL_EN_BIT];
                irqEnable  <= hwdata[i2cmsa_pkg::CTRL_IE_BIT];
                sleepMode  <= hwdata[i2cmsa_pkg::CTRL_SLEEP_BIT];
            end
            if (isWrite(i2cmsa_pkg::RELOAD_ADDR)) begin
                baud_reload_value <= hwdata[i2cmsa_pkg::RELOAD_WIDTH-1:0];
            end
        end
    end

    // second control register: condition requests
    always_ff @(posedge clk_sys) begin
        if (!nrst || !portEnable || collEvent) begin
            second_control_reg <= '0;
        end else if (startDone) begin
            second_control_reg[i2cmsa_pkg::CTRL2_START_BIT] <= 1'b0;
        end else if (isWrite(i2cmsa_pkg::CTRL2_ADDR) && !startBusy
                     && !second_control_reg[i2cmsa_pkg::CTRL2_START_BIT]) begin
            second_control_reg <= hwdata[i2cmsa_pkg::CTRL2_REQ_WIDTH-1:0];
        end
    end

    // start sequence state machine
    always_comb begin
        next_state = state;
        timerLoad  = 1'b0;
        timerRun   = 1'b0;
        startDone  = 1'b0;
        startColl  = 1'b0;
        case (state)
            i2cmsa_pkg::ST_IDLE: begin
                if (portEnable && second_control_reg[i2cmsa_pkg::CTRL2_START_BIT]) begin
                    if (lines.sda && lines.scl) begin
                        timerLoad  = 1'b1;
                        next_state = i2cmsa_pkg::ST_WAIT_LOW;
                    end else begin
                        startColl = 1'b1;
                    end
                end
            end
            i2cmsa_pkg::ST_WAIT_LOW: begin
                timerRun = 1'b1;
                if (!lines.scl || !lines.sda) begin
                    startColl  = 1'b1;
                    next_state = i2cmsa_pkg::ST_IDLE;
                end else if (timerExpired) begin
                    timerLoad  = 1'b1;
                    next_state = i2cmsa_pkg::ST_HOLD_LOW;
                end
            end
            i2cmsa_pkg::ST_HOLD_LOW: begin
                timerRun = 1'b1;
                if (timerExpired) begin
                    startDone  = 1'b1;
                    next_state = i2cmsa_pkg::ST_IDLE;
                end
            end
            default: next_state = i2cmsa_pkg::ST_IDLE;
        endcase
        if (!portEnable) begin
            next_state = i2cmsa_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state <= i2cmsa_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    i2cmsa_baud_timer u_baud_timer (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .load        (timerLoad),
        .run         (timerRun),
        .reloadValue (baud_reload_value),
        .expired     (timerExpired)
    );

    // arbitration: released data line read back low
    assign arbLost   = portEnable && arbPhase && intendSda && !lines.sda
                       && lines.scl;
    assign collEvent = startColl || arbLost;

    // bus condition detection
    assign startEdge = linesPrev.sda && !lines.sda && lines.scl && linesPrev.scl;
    assign stopEdge  = !linesPrev.sda && lines.sda && lines.scl && linesPrev.scl;

    // line drivers: data held low from start until released
    always_ff @(posedge clk_sys) begin
        if (!nrst || !portEnable || collEvent) begin
            drive <= '0;
        end else if (state == i2cmsa_pkg::ST_WAIT_LOW && next_state
                     == i2cmsa_pkg::ST_HOLD_LOW) begin
            drive.sdaOe <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        sdaOut <= 1'b0;
        sclOut <= 1'b0;
        if (!nrst) begin
            sdaOe <= 1'b0;
            sclOe <= 1'b0;
        end else begin
            sdaOe <= drive.sdaOe;
            sclOe <= drive.sclOe;
        end
    end

    // start-seen, stop-seen and bus busy
    always_ff @(posedge clk_sys) begin
        if (!nrst || !portEnable) begin
            start_seen <= 1'b0;
            stop_seen  <= 1'b0;
            busBusy    <= 1'b0;
        end else if (startEdge) begin
            start_seen <= 1'b1;
            stop_seen  <= 1'b0;
            busBusy    <= 1'b1;
        end else if (stopEdge) begin
            start_seen <= 1'b0;
            stop_seen  <= 1'b1;
            busBusy    <= 1'b0;
        end
    end

    // collision flag: set wins over software clear
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            collision_flag <= 1'b0;
        end else if (collEvent) begin
            collision_flag <= 1'b1;
        end else if (isWrite(i2cmsa_pkg::STATUS_ADDR) && hwdata[i2cmsa_pkg::ST_COLL_BIT]) begin
            collision_flag <= 1'b0;
        end
    end

    // port event flag: stop on busy bus, byte done, address match
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            port_event_flag <= 1'b0;
        end else if ((stopEdge && busBusy) || byteDone || addrMatch) begin
            port_event_flag <= 1'b1;
        end else if (isWrite(i2cmsa_pkg::STATUS_ADDR) && hwdata[i2cmsa_pkg::ST_EVENT_BIT]) begin
            port_event_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            portIrq <= 1'b0;
            wakeReq <= 1'b0;
        end else begin
            portIrq <= irqEnable && port_event_flag;
            wakeReq <= sleepMode && irqEnable && portEnable && (byteDone || addrMatch);
        end
    end

    // transmit buffer, write collision and restart after collision
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            transmit_buffer      <= i2cmsa_pkg::BYTE_RESET;
            buffer_full_flag     <= 1'b0;
            write_collision_flag <= 1'b0;
            afterColl            <= 1'b0;
            txRestart            <= 1'b0;
        end else begin
            txRestart <= 1'b0;
            if (collEvent) begin
                afterColl <= 1'b1;
            end
            if (collEvent && txActive) begin
                buffer_full_flag <= 1'b0;
            end else if (byteDone) begin
                buffer_full_flag <= 1'b0;
            end
            if (isWrite(i2cmsa_pkg::TXBUF_ADDR)) begin
                if (startBusy) begin
                    write_collision_flag <= 1'b1;
                end else begin
                    transmit_buffer  <= hwdata[7:0];
                    buffer_full_flag <= 1'b1;
                    txRestart        <= afterColl;
                    afterColl        <= 1'b0;
                end
            end else if (isWrite(i2cmsa_pkg::STATUS_ADDR)
                         && hwdata[i2cmsa_pkg::ST_WRITE_COLLISION_FLAG_BIT]) begin
                write_collision_flag <= 1'b0;
            end
        end
    end
endmodule

// >>> core/i2cmsa_pkg.sv
// package: register map, field positions, reset values and types of the start/arbitration block
package i2cmsa_pkg;

    // register byte addresses
    localparam logic [7:0] CTRL_ADDR      = 8'h00;
    localparam logic [7:0] CTRL2_ADDR     = 8'h04;
    localparam logic [7:0] STATUS_ADDR    = 8'h08;
    localparam logic [7:0] RELOAD_ADDR    = 8'h0c;
    localparam logic [7:0] TXBUF_ADDR     = 8'h10;
    localparam logic [7:0] SHIFT_ADDR     = 8'h14;

    // control register fields
    localparam int CTRL_EN_BIT            = 0;
    localparam int CTRL_IE_BIT            = 1;
    localparam int CTRL_SLEEP_BIT         = 2;

    // second control register fields
    localparam int CTRL2_START_BIT        = 0;
    localparam int CTRL2_REQ_WIDTH        = 5;

    // status register fields
    localparam int ST_BUSY_BIT            = 0;
    localparam int ST_BFULL_BIT           = 1;
    localparam int ST_START_SEEN_BIT      = 3;
    localparam int ST_STOP_SEEN_BIT       = 4;
    localparam int ST_COLL_BIT            = 5;
    localparam int ST_WRITE_COLLISION_FLAG_BIT            = 6;
    localparam int ST_EVENT_BIT           = 7;

    // reload field
    localparam int RELOAD_WIDTH           = 7;
    localparam logic [6:0] RELOAD_RESET   = 7'h04;

    // reset values
    localparam logic [7:0] BYTE_RESET     = 8'h00;
    localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

    // ahb-lite codes
    localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
    localparam logic [2:0] HSIZE_WORD     = 3'h2;

    // start sequence states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_LOW,
        ST_HOLD_LOW
    } i2cmsa_state_t;

    // synchronised bus line levels
    typedef struct packed {
        logic sda;
        logic scl;
    } i2cmsa_lines_t;

    // bus line driver (enable high pulls the line low)
    typedef struct packed {
        logic sdaOe;
        logic sclOe;
    } i2cmsa_drive_t;

endpackage

// >>> verification/i2cmsa_bus_model.sv
// partner model: pulled-up two-wire bus with another master on it
`timescale 1ns/1ps
module i2cmsa_bus_model (
    // clock
    input wire logic clk_sys,
    // device drivers
    input wire logic sdaOe,
    input wire logic sclOe,
    // resolved levels
    output logic     sdaLine,
    output logic     sclLine
);
    logic pullSda = 1'b0;
    logic pullScl = 1'b0;
    // open drain with pull-up: a released line reads high
    assign sdaLine = !(sdaOe || pullSda);
    assign sclLine = !(sclOe || pullScl);
    // slow party stretching the clock line
    task automatic hold_scl(input logic v);
        pullScl <= v;
    endtask
    // start, one clock pulse at the link rate, stop
    task automatic frame();
        if (sdaLine && sclLine) begin
            pullSda <= 1'b1;
            repeat (4) @(posedge clk_sys);
            pullScl <= 1'b1;
            repeat (4) @(posedge clk_sys);
            pullScl <= 1'b0;
            repeat (4) @(posedge clk_sys);
            pullSda <= 1'b0;
        end
    endtask
endmodule

// >>> verification/i2cmsa_props.sv
// checker: port assertions of the start and arbitration block
`timescale 1ns/1ps
module i2cmsa_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // register bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // bus pins
    input wire logic sdaIn,
    input wire logic sclIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic sclOut,
    input wire logic sclOe,
    // hooks and system
    input wire logic byteDone,
    input wire logic addrMatch,
    input wire logic intendSda,
    input wire logic arbPhase,
    input wire logic portIrq,
    input wire logic wakeReq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_arb_lost;
        (arbPhase && intendSda && !sdaIn && sclIn) [*2];
    endsequence
    sequence s_scl_low;
        (!sdaOe && !sclIn) [*6];
    endsequence
    a_scl_released: assert property (!sclOe && !sclOut)
        else $error("clock line driven");
    a_sda_low_only: assert property (!sdaOut)
        else $error("data line driven high");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_reset_clear: assert property ($rose(nrst) |-> !sdaOe && !portIrq && !wakeReq)
        else $error("outputs active after reset");
    a_start_high: assert property ($rose(sdaOe) |-> $past(sclIn, 3) && $past(sdaIn, 3))
        else $error("start driven on a low line");
    a_scl_low_block: assert property (s_scl_low |=> !sdaOe [*2])
        else $error("start driven while clock low");
    a_arb_release: assert property (s_arb_lost |-> ##[0:4] !sdaOe)
        else $error("data line kept after lost arbitration");
    a_wake_cause: assert property (wakeReq |-> $past(byteDone || addrMatch))
        else $error("wake without byte or match");
endmodule
bind i2cmsa_core i2cmsa_props i2cmsa_props_inst (.clk_sys(clk_sys), .nrst(nrst),
    .hreadyout(hreadyout), .hresp(hresp), .sdaIn(sdaIn), .sclIn(sclIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .sclOut(sclOut), .sclOe(sclOe), .byteDone(byteDone),
    .addrMatch(addrMatch), .intendSda(intendSda), .arbPhase(arbPhase),
    .portIrq(portIrq), .wakeReq(wakeReq));

// >>> verification/testbench.sv
// testbench: scenarios for the start and arbitration block
`timescale 1ns/1ps
module testbench;
    logic        clk_sys, nrst, hsel, hwrite, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, rdata;
    logic        byteDone, addrMatch, txActive, intendSda, arbPhase;
    logic        sdaLine, sclLine, sdaOut, sdaOe, sclOut, sclOe;
    logic        portIrq, wakeReq, txRestart;
    int          bad_count = 0;
    int          tests_run = 0;
    i2cmsa_core i2cmsa_core_inst (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(i2cmsa_pkg::HSIZE_WORD), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sdaIn(sdaLine), .sclIn(sclLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .sclOut(sclOut),
        .sclOe(sclOe), .byteDone(byteDone), .addrMatch(addrMatch), .txActive(txActive),
        .intendSda(intendSda), .arbPhase(arbPhase), .portIrq(portIrq), .wakeReq(wakeReq),
        .txRestart(txRestart));
    i2cmsa_bus_model i2cmsa_bus_model_inst (.clk_sys(clk_sys), .sdaOe(sdaOe),
        .sclOe(sclOe), .sdaLine(sdaLine), .sclLine(sclLine));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d of %0d compares", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic give_up(input logic ok);
        if (!ok) begin
            bad_count++;
            close_out();
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 200);
        give_up(hreadyout === 1'b1);
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= i2cmsa_pkg::HTRANS_NONSEQ;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
        rdata = hrdata;
    endtask
    task automatic wait_oe(input logic v);
        int n;
        n = 0;
        while (sdaOe !== v && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        give_up(sdaOe === v);
    endtask
    task automatic poll_start_clear();
        int n;
        n = 0;
        do begin
            xfer(i2cmsa_pkg::CTRL2_ADDR, 1'b0, 32'h0);
            n++;
        end while (rdata[0] !== 1'b0 && n < 100);
        give_up(rdata[0] === 1'b0);
    endtask
    // sel 0 restart, 1 wake, 2 interrupt
    task automatic pulse_seen(input logic [1:0] sel, input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (10) begin
            @(negedge clk_sys);
            if ((sel == 2'd2 ? portIrq : sel == 2'd1 ? wakeReq : txRestart) === 1'b1) seen = 1'b1;
        end
        @(posedge clk_sys);
        chk(seen, exp);
    endtask
    task automatic hook(input logic m);
        {byteDone, addrMatch} <= m ? 2'h1 : 2'h2;
        @(posedge clk_sys);
        {byteDone, addrMatch} <= 2'h0;
    endtask
    task automatic s_reset();
        chk(sdaOe, 1'b0);
        xfer(i2cmsa_pkg::STATUS_ADDR, 1'b0, 32'h0);
        chk(rdata, 32'h0);
        xfer(i2cmsa_pkg::RELOAD_ADDR, 1'b0, 32'h0);
        chk(rdata, {25'h0, i2cmsa_pkg::RELOAD_RESET});
        xfer(8'h20, 1'b0, 32'h0);
        chk(rdata, 32'h0);
    endtask
    task automatic s_start();
        xfer(i2cmsa_pkg::CTRL_ADDR, 1'b1, 32'h1);
        xfer(i2cmsa_pkg::RELOAD_ADDR, 1'b1, 32'h30);
        xfer(i2cmsa_pkg::STATUS_ADDR, 1'b0, 32'h0);
        chk(rdata[4:3], 2'h0);
        xfer(i2cmsa_pkg::CTRL2_ADDR, 1'b1, 32'h1);
        wait_oe(1'b1);
        xfer(i2cmsa_pkg::TXBUF_ADDR, 1'b1, 32'ha5);
        xfer(i2cmsa_pkg::CTRL2_ADDR, 1'b1, 32'h1e);
        xfer(i2cmsa_pkg::CTRL2_ADDR, 1'b0, 32'h0);
        chk(rdata[4:0], 5'h01);
        xfer(i2cmsa_pkg::TXBUF_ADDR, 1'b0, 32'h0);
        chk(rdata[7:0], 8'h00);
        xfer(i2cmsa_pkg::STATUS_ADDR, 1'b0, 32'h0);
        chk(rdata[6], 1'b1);
        chk(rdata[3], 1'b1);
        poll_start_clear();
        chk(sdaOe, 1'b1);
    endtask
    task automatic s_arb();
        xfer(i2cmsa_pkg::TXBUF_ADDR, 1'b1, 32'h3c);
        {txActive, arbPhase, intendSda} <= 3'h7;
        wait_oe(1'b0);
        {txActive, arbPhase, intendSda} <= 3'h0;
        xfer(i2cmsa_pkg::STATUS_ADDR, 1'b0, 32'h0);
        chk(rdata[5], 1'b1);
        chk(rdata[1], 1'b0);
        xfer(i2cmsa_pkg::TXBUF_ADDR, 1'b1, 32'h5a);
        pulse_seen(2'd0, 1'b1);
        xfer(i2cmsa_pkg::STATUS_ADDR, 1'b1, 32'he0);
    endtask
    task automatic s_abort();
        i2cmsa_bus_model_inst.hold_scl(1'b1);
        xfer(i2cmsa_pkg::CTRL2_ADDR, 1'b1, 32'h1);
        poll_start_clear();
        chk(sdaOe, 1'b0);
        xfer(i2cmsa_pkg::STATUS_ADDR, 1'b0, 32'h0);
        chk(rdata[5], 1'b1);
        i2cmsa_bus_model_inst.hold_scl(1'b0);
        xfer(i2cmsa_pkg::STATUS_ADDR, 1'b1, 32'he0);
    endtask
    task automatic s_frame();
        xfer(i2cmsa_pkg::CTRL_ADDR, 1'b1, 32'h3);
        i2cmsa_bus_model_inst.frame();
        pulse_seen(2'd2, 1'b1);
        xfer(i2cmsa_pkg::STATUS_ADDR, 1'b0, 32'h0);
        chk(rdata[4], 1'b1);
    endtask
    task automatic s_sleep();
        xfer(i2cmsa_pkg::CTRL_ADDR, 1'b1, 32'h7);
        hook(1'b1);
        pulse_seen(2'd1, 1'b1);
        xfer(i2cmsa_pkg::CTRL_ADDR, 1'b1, 32'h6);
        hook(1'b0);
        pulse_seen(2'd1, 1'b0);
        xfer(i2cmsa_pkg::STATUS_ADDR, 1'b0, 32'h0);
        chk(rdata[4:3], 2'h0);
    endtask
    task automatic s_midreset();
        xfer(i2cmsa_pkg::CTRL_ADDR, 1'b1, 32'h1);
        xfer(i2cmsa_pkg::CTRL2_ADDR, 1'b1, 32'h1);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        s_reset();
        xfer(i2cmsa_pkg::CTRL2_ADDR, 1'b0, 32'h0);
        chk(rdata, 32'h0);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        {nrst, hsel, hwrite, haddr, htrans, hwdata} = 45'h0;
        {byteDone, addrMatch, txActive, intendSda, arbPhase} = 5'h0;
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        s_reset();
        s_start();
        s_arb();
        s_abort();
        s_frame();
        s_sleep();
        s_midreset();
        close_out();
    end
endmodule
